// >>> hw/deac_top.v
// Data EEPROM access block: AXI4-Lite register slave, byte array,
// unlock checker and self-timed byte write.
// Assumes a single 10 MHz aclk; reset-cause inputs are synchronous.
//
// How it works
// - Control register bits 7 to 4 always read back as zero.
// - Read and write start bits are set-only; hardware clears them.
// - Write start is refused unless program enable was already set.
// - Program enable is zero after power-up reset.
// - Hardware never clears program enable, not even at write end.
// - Abort flag sets when a reset cuts a running write short.
// - Data and address registers survive the aborting reset.
// - Write end clears write start and sets the sticky done flag.
// - Unlock register stores nothing and reads as zero.
// - Read start loads the addressed byte on the next cycle.
// - Data register holds until another read or a software write.
// - Key 55h, then AAh, then write start; otherwise no write.
// - Steps outside the allowed cycle spacing discard the write.
// - Clearing program enable does not disturb a running write.
// - No write may start while the power-up timer runs.
// - A byte write erases the location before programming it.
// - Write length comes from an internal timer, not software.
// - Small variant uses seven address bits, large one all eight.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "deac_map.vh"

module deac_top #(
  parameter integer PWRT_CYCLES = `DEAC_PWRT_CYC,
  parameter integer WRITE_CYCLES = `DEAC_WRITE_CYC,
  parameter [4:0] SEQ_GAP = `DEAC_SEQ_GAP,
  parameter integer BIG_ARRAY = `DEAC_BIG_ARRAY
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [`DEAC_AXI_AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [`DEAC_AXI_AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Reset causes other than power-up
  input wire external_reset_pin,
  input wire watchdog_timer,
  input wire wdt_in_sleep,
  input wire brownout_reset,
  // Power-up timer strap
  input wire pwrt_enable,
  // Status
  output reg nvm_done_flag,
  output reg program_abort_flag,
  output wire write_busy
);

////////////////////////////////////////////////////////////////////////
// Address decode helpers

localparam [1:0] LANE_ZERO = 2'h0;
localparam [3:0] CTRL_PAD = 4'h0;
localparam [6:0] FLAG_PAD = 7'h00;
localparam [23:0] DATA_PAD = 24'h00_0000;
localparam [31:0] WORD_ZERO = 32'h0000_0000;

function mapped;
  input [`DEAC_AXI_AW-1:0] a;
  begin
    mapped = (a[1:0] == LANE_ZERO) &&
      ((a[9:2] == `DEAC_IDX_FLAG) || (a[9:2] == `DEAC_IDX_DATA) ||
       (a[9:2] == `DEAC_IDX_ADDR) || (a[9:2] == `DEAC_IDX_CTRL) ||
       (a[9:2] == `DEAC_IDX_UNLK)) &&
      (a[`DEAC_AXI_AW-1:10] == LANE_ZERO);
  end
endfunction

////////////////////////////////////////////////////////////////////////
// Register state

reg rd_ff;
reg wr_ff;
reg en_ff;
reg [7:0] data_ff;
reg [7:0] addr_ff;
reg [7:0] tgt_addr_ff;
reg [7:0] tgt_data_ff;
reg started_ff;
reg [7:0] mem_q [0:`DEAC_DEPTH-1];

// AXI write side holding registers
reg aw_hold_ff;
reg [`DEAC_AXI_AW-1:0] aw_addr_ff;
reg w_hold_ff;
reg [7:0] w_data_ff;
reg w_lane_ff;

wire armed;
wire tmr_busy;
wire tmr_done;
wire pwrt_busy;

////////////////////////////////////////////////////////////////////////
// Reset causes

// A watchdog time-out while asleep is a wake-up, not a reset
wire warm = external_reset_pin | brownout_reset |
  (watchdog_timer & ~wdt_in_sleep);

////////////////////////////////////////////////////////////////////////
// AXI4-Lite write channel

// Address and data are taken in either order, one write at a time
assign s_axi_awready = ~aw_hold_ff & ~s_axi_bvalid;
assign s_axi_wready = ~w_hold_ff & ~s_axi_bvalid;

wire do_wr = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
wire wr_ok = do_wr & mapped(aw_addr_ff);
wire wr_eff = wr_ok & w_lane_ff & ~warm;
wire [7:0] wr_idx = aw_addr_ff[9:2];
wire hit_flag = wr_eff & (wr_idx == `DEAC_IDX_FLAG);
wire hit_data = wr_eff & (wr_idx == `DEAC_IDX_DATA);
wire hit_addr = wr_eff & (wr_idx == `DEAC_IDX_ADDR);
wire hit_ctrl = wr_eff & (wr_idx == `DEAC_IDX_CTRL);
wire hit_unlk = wr_eff & (wr_idx == `DEAC_IDX_UNLK);

always @(posedge aclk) begin
  if (!aresetn) begin
    aw_hold_ff <= 1'b0;
    aw_addr_ff <= {`DEAC_AXI_AW{1'b0}};
    w_hold_ff <= 1'b0;
    w_data_ff <= `DEAC_BYTE_ZERO;
    w_lane_ff <= 1'b0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `DEAC_RESP_OKAY;
  end else begin
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_hold_ff <= 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_ff <= 1'b1;
      w_data_ff <= s_axi_wdata[7:0];
      w_lane_ff <= s_axi_wstrb[0];
    end else if (do_wr) begin
      w_hold_ff <= 1'b0;
    end
    if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `DEAC_RESP_OKAY : `DEAC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Unlock checker and timers

// Any write other than a key write breaks or consumes the sequence
deac_unlock #(
  .SEQ_GAP(SEQ_GAP)
) u_unlock (
  .aclk(aclk),
  .aresetn(aresetn),
  .clr(warm),
  .key_wr(hit_unlk),
  .key_data(w_data_ff),
  .other_wr(do_wr & ~hit_unlk),
  .armed(armed)
);

// Effective address drops bit 7 on the small array
wire [7:0] eff_addr = (BIG_ARRAY != 0) ? addr_ff :
  {1'b0, addr_ff[6:0]};

wire start_wr = hit_ctrl & w_data_ff[`DEAC_CTRL_WR] & en_ff & armed &
  ~wr_ff & ~pwrt_busy;

deac_count #(
  .WIDTH(`DEAC_CNT_W),
  .LEN(WRITE_CYCLES)
) u_write_timer (
  .aclk(aclk),
  .aresetn(aresetn),
  .start(start_wr),
  .stop(warm),
  .busy(tmr_busy),
  .done_ff(tmr_done)
);

// Strap is caught by the first clocked cycle after reset release
deac_count #(
  .WIDTH(`DEAC_CNT_W),
  .LEN(PWRT_CYCLES)
) u_pwrt (
  .aclk(aclk),
  .aresetn(aresetn),
  .start(~started_ff & pwrt_enable),
  .stop(1'b0),
  .busy(pwrt_busy),
  .done_ff()
);

assign write_busy = wr_ff;

////////////////////////////////////////////////////////////////////////
// Control, flag, data and address registers

always @(posedge aclk) begin
  if (!aresetn) begin
    rd_ff <= 1'b0;
    wr_ff <= 1'b0;
    en_ff <= 1'b0;
    program_abort_flag <= 1'b0;
    nvm_done_flag <= 1'b0;
    data_ff <= `DEAC_BYTE_ZERO;
    addr_ff <= `DEAC_BYTE_ZERO;
    tgt_addr_ff <= `DEAC_BYTE_ZERO;
    tgt_data_ff <= `DEAC_BYTE_ZERO;
    started_ff <= 1'b0;
  end else if (warm) begin
    // Data, address and program enable are kept for a retry
    rd_ff <= 1'b0;
    wr_ff <= 1'b0;
    nvm_done_flag <= 1'b0;
    if (wr_ff) begin
      program_abort_flag <= 1'b1;
    end
    started_ff <= 1'b1;
  end else begin
    started_ff <= 1'b1;
    // Read start lives exactly one cycle
    if (rd_ff) begin
      rd_ff <= 1'b0;
    end else if (hit_ctrl && w_data_ff[`DEAC_CTRL_RD]) begin
      rd_ff <= 1'b1;
    end
    if (tmr_done) begin
      wr_ff <= 1'b0;
    end else if (start_wr) begin
      wr_ff <= 1'b1;
    end
    // Only software touches enable; the timer ignores it once running
    if (hit_ctrl) begin
      en_ff <= w_data_ff[`DEAC_CTRL_EN];
      program_abort_flag <= w_data_ff[`DEAC_CTRL_ERR];
    end
    // Completion beats a clear arriving in the same cycle
    if (tmr_done) begin
      nvm_done_flag <= 1'b1;
    end else if (hit_flag) begin
      nvm_done_flag <= w_data_ff[`DEAC_FLAG_DONE];
    end
    if (rd_ff) begin
      data_ff <= mem_q[eff_addr];
    end else if (hit_data) begin
      data_ff <= w_data_ff;
    end
    if (hit_addr) begin
      addr_ff <= w_data_ff;
    end
    // Latch the target so later register writes cannot skew the write
    if (start_wr) begin
      tgt_addr_ff <= eff_addr;
      tgt_data_ff <= data_ff;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Array

// Nonvolatile contents: no reset; an aborted write leaves it erased
always @(posedge aclk) begin
  if (start_wr) begin
    mem_q[eff_addr] <= `DEAC_ERASED;
  end else if (tmr_done && !warm) begin
    // A reset landing on the last cycle still counts as an abort
    mem_q[tgt_addr_ff] <= tgt_data_ff;
  end
end

////////////////////////////////////////////////////////////////////////
// AXI4-Lite read channel

assign s_axi_arready = ~s_axi_rvalid;

reg [7:0] rd_byte;

always @* begin
  rd_byte = `DEAC_BYTE_ZERO;
  case (s_axi_araddr[9:2])
    `DEAC_IDX_FLAG: rd_byte = {nvm_done_flag, FLAG_PAD};
    `DEAC_IDX_DATA: rd_byte = data_ff;
    `DEAC_IDX_ADDR: rd_byte = addr_ff;
    `DEAC_IDX_CTRL: rd_byte = {CTRL_PAD, program_abort_flag, en_ff,
      wr_ff, rd_ff};
    `DEAC_IDX_UNLK: rd_byte = `DEAC_BYTE_ZERO;
    default: rd_byte = `DEAC_BYTE_ZERO;
  endcase
end

always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= WORD_ZERO;
    s_axi_rresp <= `DEAC_RESP_OKAY;
  end else if (s_axi_arvalid && s_axi_arready) begin
    s_axi_rvalid <= 1'b1;
    if (mapped(s_axi_araddr)) begin
      s_axi_rdata <= {DATA_PAD, rd_byte};
      s_axi_rresp <= `DEAC_RESP_OKAY;
    end else begin
      s_axi_rdata <= WORD_ZERO;
      s_axi_rresp <= `DEAC_RESP_SLVERR;
    end
  end else if (s_axi_rready) begin
    s_axi_rvalid <= 1'b0;
  end
end

endmodule
`default_nettype wire

// >>> hw/deac_map.vh
// Register indices, field positions and timing for the data EEPROM block.
// Definitions only; included by every design file of the block.
`ifndef DEAC_MAP_VH
`define DEAC_MAP_VH

// Register indices; the AXI byte address is four times the index
`define DEAC_IDX_FLAG 8'h0C
`define DEAC_IDX_DATA 8'h9A
`define DEAC_IDX_ADDR 8'h9B
`define DEAC_IDX_CTRL 8'h9C
`define DEAC_IDX_UNLK 8'h9D
`define DEAC_AXI_AW 12

// Control register fields
`define DEAC_CTRL_RD 0
`define DEAC_CTRL_WR 1
`define DEAC_CTRL_EN 2
`define DEAC_CTRL_ERR 3
// Peripheral flag register field
`define DEAC_FLAG_DONE 7

// Unlock keys and array values
`define DEAC_KEY1 8'h55
`define DEAC_KEY2 8'hAA
`define DEAC_ERASED 8'hFF
`define DEAC_BYTE_ZERO 8'h00
`define DEAC_DEPTH 256
`define DEAC_BIG_ARRAY 1

// AXI responses
`define DEAC_RESP_OKAY 2'h0
`define DEAC_RESP_SLVERR 2'h2

// Timing: power-up timer in ms, clock in Hz
`define DEAC_CLK_HZ 32'h0098_9680
`define DEAC_MS_PER_S 32'h0000_03E8
`define DEAC_PWRT_MS 32'h0000_0048
`define DEAC_PWRT_CYC (`DEAC_PWRT_MS * (`DEAC_CLK_HZ / `DEAC_MS_PER_S))
`define DEAC_WRITE_CYC 32'h0000_0028
`define DEAC_SEQ_GAP 5'h10
`define DEAC_CNT_W 20

`endif

// >>> hw/deac_count.v
// One-shot down counter: loaded by start, pulses done when it runs out.
// Assumes start and stop are one-cycle strobes in the aclk domain.
`timescale 1ns/1ps
`default_nettype none
`include "deac_map.vh"

module deac_count #(
  parameter integer WIDTH = `DEAC_CNT_W,
  parameter integer LEN = 1
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Control
  input wire start,
  input wire stop,
  // Status
  output wire busy,
  output reg done_ff
);

localparam [WIDTH-1:0] LEN_W = LEN[WIDTH-1:0];
localparam [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};
localparam [WIDTH-1:0] ZERO = {WIDTH{1'b0}};

reg [WIDTH-1:0] count_ff;
reg [WIDTH-1:0] nxt_count;
reg nxt_done;

assign busy = (count_ff != ZERO);

always @* begin
  nxt_count = count_ff;
  nxt_done = 1'b0;
  // Stop wins so an aborted run never reports completion
  if (stop) begin
    nxt_count = ZERO;
  end else if (start) begin
    nxt_count = LEN_W;
  end else if (busy) begin
    nxt_count = count_ff - ONE;
    nxt_done = (count_ff == ONE);
  end
end

always @(posedge aclk) begin
  if (!aresetn) begin
    count_ff <= ZERO;
    done_ff <= 1'b0;
  end else begin
    count_ff <= nxt_count;
    done_ff <= nxt_done;
  end
end

endmodule
`default_nettype wire

// >>> hw/deac_unlock.v
// Unlock sequence checker: first key, second key, then the start write.
// Assumes one strobe per register write; gap limits each step's spacing.
`timescale 1ns/1ps
`default_nettype none
`include "deac_map.vh"

module deac_unlock #(
  parameter [4:0] SEQ_GAP = `DEAC_SEQ_GAP
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  input wire clr,
  // Write strobes
  input wire key_wr,
  input wire [7:0] key_data,
  input wire other_wr,
  // Status
  output wire armed
);

localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_HALF = 2'h1;
localparam [1:0] ST_ARMED = 2'h2;
localparam [4:0] GAP_ZERO = 5'h00;
localparam [4:0] GAP_ONE = 5'h01;

reg [1:0] state_ff;
reg [1:0] nxt_state;
reg [4:0] gap_ff;
reg [4:0] nxt_gap;

assign armed = (state_ff == ST_ARMED);

always @* begin
  nxt_state = state_ff;
  nxt_gap = gap_ff + GAP_ONE;
  if (clr || other_wr) begin
    nxt_state = ST_IDLE;
    nxt_gap = GAP_ZERO;
  end else if (key_wr) begin
    nxt_gap = GAP_ZERO;
    case (state_ff)
      ST_HALF: nxt_state = (key_data == `DEAC_KEY2) ? ST_ARMED :
        (key_data == `DEAC_KEY1) ? ST_HALF : ST_IDLE;
      default: nxt_state = (key_data == `DEAC_KEY1) ? ST_HALF : ST_IDLE;
    endcase
  end else if (state_ff == ST_IDLE) begin
    nxt_gap = GAP_ZERO;
  end else if (gap_ff >= SEQ_GAP) begin
    // Too slow between steps: the cycle count no longer matches
    nxt_state = ST_IDLE;
    nxt_gap = GAP_ZERO;
  end
end

always @(posedge aclk) begin
  if (!aresetn) begin
    state_ff <= ST_IDLE;
    gap_ff <= GAP_ZERO;
  end else begin
    state_ff <= nxt_state;
    gap_ff <= nxt_gap;
  end
end

endmodule
`default_nettype wire

// >>> verif/deac_array_model.sv
// Reference contents of the data EEPROM array for the bench.
// Assumes the bench calls erase at write start and prog at write end.
`timescale 1ns/1ps
`default_nettype none
`include "deac_map.vh"
module deac_array_model;
  logic [7:0] mem [0:255];
  // An aborted write leaves the location erased, never half written
  task automatic erase(input logic [7:0] a);
    mem[a] = `DEAC_ERASED;
  endtask
  task automatic prog(input logic [7:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask
endmodule
`default_nettype wire

// >>> verif/deac_top_sva.sv
// Checker for the data EEPROM block, bound to its top module.
// Assumes the top ports only; counts follow the bound instance.
`timescale 1ns/1ps
`default_nettype none
`include "deac_map.vh"
module deac_top_sva #(
  parameter integer PWRT_CYCLES = 50,
  parameter integer WRITE_CYCLES = 5
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`DEAC_AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Reset causes and status
  input wire logic external_reset_pin,
  input wire logic watchdog_timer,
  input wire logic wdt_in_sleep,
  input wire logic brownout_reset,
  input wire logic pwrt_enable,
  input wire logic nvm_done_flag,
  input wire logic program_abort_flag,
  input wire logic write_busy
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic warm;
  logic strap_ff;
  logic [7:0] busy_cnt_ff;
  logic [31:0] since_ff;
  assign warm = external_reset_pin | brownout_reset |
    (watchdog_timer & ~wdt_in_sleep);
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy_cnt_ff <= 8'h00;
      since_ff <= 32'h0000_0000;
      strap_ff <= 1'b0;
    end else begin
      busy_cnt_ff <= write_busy ? busy_cnt_ff + 8'h01 : 8'h00;
      if (since_ff == 32'h0000_0000) strap_ff <= pwrt_enable;
      if (since_ff != 32'hFFFF_FFFF) since_ff <= since_ff + 32'h0000_0001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_rd_take(logic [11:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  sequence s_wr_end;
    $fell(write_busy) && !$past(warm);
  endsequence
  chk_ctrl_upper: assert property (
    s_rd_take({2'h0, `DEAC_IDX_CTRL, 2'h0}) |=> s_axi_rdata[31:4] == 0)
    else $error("control upper bits not zero");
  chk_unlock_zero: assert property (
    s_rd_take({2'h0, `DEAC_IDX_UNLK, 2'h0}) |=> s_axi_rdata == 0)
    else $error("unlock register read not zero");
  chk_write_len: assert property (
    s_wr_end |-> busy_cnt_ff == WRITE_CYCLES + 1)
    else $error("write length wrong");
  chk_done_set: assert property (s_wr_end |-> nvm_done_flag)
    else $error("done flag not set at write end");
  chk_abort_set: assert property (
    warm && write_busy |=> program_abort_flag && !write_busy)
    else $error("abort not flagged");
  chk_busy_hold: assert property (
    write_busy && !warm |=> write_busy || nvm_done_flag)
    else $error("write start cleared early");
  chk_pwrt_block: assert property (
    strap_ff && since_ff < PWRT_CYCLES |-> !$rose(write_busy))
    else $error("write during power-up timer");
  chk_done_keep: assert property (
    nvm_done_flag && !warm && !$past(s_axi_wvalid) |=> nvm_done_flag)
    else $error("done flag dropped");
  chk_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  chk_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_read_gate: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
endmodule
bind deac_top deac_top_sva #(.PWRT_CYCLES(PWRT_CYCLES),
  .WRITE_CYCLES(WRITE_CYCLES)) i_sva (.aclk, .aresetn, .s_axi_wvalid,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .external_reset_pin, .watchdog_timer, .wdt_in_sleep,
  .brownout_reset, .pwrt_enable, .nvm_done_flag, .program_abort_flag,
  .write_busy);
`default_nettype wire

// >>> verif/test_deac_top.sv
// Self-checking bench for the data EEPROM block over AXI4-Lite.
// Assumes the array model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "deac_map.vh"
module test_deac_top;
  localparam int WCYC = 5;
  localparam int PCYC = 50;
  localparam logic [11:0] A_FLG = {2'h0, `DEAC_IDX_FLAG, 2'h0};
  localparam logic [11:0] A_DAT = {2'h0, `DEAC_IDX_DATA, 2'h0};
  localparam logic [11:0] A_ADR = {2'h0, `DEAC_IDX_ADDR, 2'h0};
  localparam logic [11:0] A_CTL = {2'h0, `DEAC_IDX_CTRL, 2'h0};
  localparam logic [11:0] A_UNL = {2'h0, `DEAC_IDX_UNLK, 2'h0};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, pwrt_enable;
  logic external_reset_pin, watchdog_timer, wdt_in_sleep, brownout_reset;
  logic nvm_done_flag, program_abort_flag, write_busy;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] a, d;
  logic [11:0] tab [5];
  int n_mismatch, compares, cyc, k;
  deac_top #(.PWRT_CYCLES(PCYC), .WRITE_CYCLES(WCYC)) i_dut (.aclk,
    .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .external_reset_pin, .watchdog_timer, .wdt_in_sleep, .brownout_reset,
    .pwrt_enable, .nvm_done_flag, .program_abort_flag, .write_busy);
  deac_array_model i_arr ();
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Handshakes are judged at the falling edge, acted on at the next rise
  task automatic wr(input logic [11:0] ad, input logic [7:0] dt);
    logic aw, w, b;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= {24'h0, dt};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] ad, output logic [31:0] q);
    logic ar, r;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge aclk);
      ar = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid;
      q = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] ad, input logic [7:0] e);
    rd(ad, v);
    chk(v, {24'h0, e});
  endtask
  task automatic seq(input logic [7:0] c);
    wr(A_UNL, `DEAC_KEY1);
    wr(A_UNL, `DEAC_KEY2);
    wr(A_CTL, c);
  endtask
  task automatic load;
    seed = xs(seed);
    a = seed[7:0];
    d = seed[15:8];
    wr(A_ADR, a);
    wr(A_DAT, d);
    wr(A_CTL, 8'h04);
    seq(8'h06);
    i_arr.erase(a);
  endtask
  task automatic idle;
    int n;
    n = 0;
    @(negedge aclk);
    while (write_busy !== 1'b0 && n < 100) begin
      @(negedge aclk);
      n++;
    end
    chk(write_busy, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, external_reset_pin, watchdog_timer} = 3'h0;
    {wdt_in_sleep, brownout_reset, aresetn} = 3'h0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    pwrt_enable = 1'b1;
    seed = 32'h0000_0014;
    tab = '{A_FLG, A_DAT, A_ADR, A_UNL, 12'h004};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(A_CTL, 8'h00);
    wr(A_CTL, 8'h04);
    seq(8'h06);
    rdc(A_CTL, 8'h04);
    for (k = 0; k < 5; k++) begin
      rd(tab[k], v);
      chk(v, 0);
      chk(resp, k == 4 ? `DEAC_RESP_SLVERR : `DEAC_RESP_OKAY);
    end
    wr(12'h004, 8'h00);
    chk(resp, `DEAC_RESP_SLVERR);
    repeat (PCYC) @(posedge aclk);
    wr(A_CTL, 8'h00);
    seq(8'h02);
    rdc(A_CTL, 8'h00);
    wr(A_CTL, 8'h04);
    wr(A_UNL, `DEAC_KEY2);
    wr(A_UNL, `DEAC_KEY1);
    wr(A_CTL, 8'h06);
    rdc(A_CTL, 8'h04);
    wr(A_UNL, `DEAC_KEY1);
    repeat (20) @(posedge aclk);
    wr(A_UNL, `DEAC_KEY2);
    wr(A_CTL, 8'h06);
    rdc(A_CTL, 8'h04);
    for (k = 0; k < 3; k++) begin
      load();
      if (k == 1) wr(A_CTL, 8'h00);
      idle();
      i_arr.prog(a, d);
      chk(nvm_done_flag, 1);
      rdc(A_CTL, k == 1 ? 8'h00 : 8'h04);
      rdc(A_FLG, 8'h80);
      wr(A_FLG, 8'h00);
      chk(resp, `DEAC_RESP_OKAY);
      rdc(A_FLG, 8'h00);
      wr(A_DAT, ~d);
      wr(A_CTL, k == 1 ? 8'h01 : 8'h05);
      rdc(A_DAT, i_arr.mem[a]);
      rdc(A_DAT, i_arr.mem[a]);
    end
    // Last pass is a watchdog while asleep, which must not abort
    for (k = 0; k < 4; k++) begin
      load();
      external_reset_pin <= (k == 0);
      watchdog_timer <= k[0];
      brownout_reset <= (k == 2);
      wdt_in_sleep <= (k == 3);
      @(posedge aclk);
      {external_reset_pin, watchdog_timer, brownout_reset} <= 3'h0;
      idle();
      chk(program_abort_flag, k != 3);
      chk(nvm_done_flag, k == 3);
      if (k == 3) i_arr.prog(a, d);
      rdc(A_ADR, a);
      rdc(A_DAT, d);
      wr(A_FLG, 8'h00);
      wr(A_CTL, 8'h05);
      rdc(A_DAT, i_arr.mem[a]);
    end
    end_sim();
  end
endmodule
`default_nettype wire
